// ---- rtl/abox_pkg.sv ----
// abox_pkg: opcode patterns, field positions, reset values for the add/bit-op execute block
// assumes: 14-bit program words, 8-bit data path, 128 file registers
package abox_pkg;
   localparam int unsigned WORD_W      = 14;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned ADDR_W      = 7;
   localparam int unsigned BITSEL_W    = 3;
   // field positions inside a program word
   localparam int unsigned ADDR_LSB    = 0;
   localparam int unsigned DEST_POS    = 7;
   localparam int unsigned BITSEL_LSB  = 7;
   localparam int unsigned NIBBLE_POS  = 4;
   // add: 00 0111 dfff ffff, matched on word[13:8]
   localparam int unsigned ADD_OP_LSB  = 8;
   localparam logic [5:0]  ADD_OP      = 6'h07;
   // bit ops: 01 xxbb bfff ffff, matched on word[13:10]
   localparam int unsigned BIT_OP_LSB  = 10;
   localparam logic [3:0]  BCLR_OP     = 4'h4;
   localparam logic [3:0]  BSET_OP     = 4'h5;
   localparam logic [3:0]  BTST_OP     = 4'h6;
   // reset values
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic        FLAG_RST    = 1'b0;

   typedef enum {
      OP_NONE,
      OP_ADD,
      OP_BCLR,
      OP_BSET,
      OP_BTST
   } abox_op_t;
endpackage : abox_pkg

// ---- rtl/abox_file_mem.sv ----
// abox_file_mem: file register array, one write port, one registered read port
// assumes: single clock; a write and read of the same address in one cycle returns new data
`timescale 1ns/10ps
`default_nettype none
module abox_file_mem #(
   parameter int unsigned AW = 7,
   parameter int unsigned DW = 8
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output var  logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];

   // write-first so back-to-back access to one register sees fresh data
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (we && (waddr == raddr)) begin
         rdata <= wdata;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule : abox_file_mem
`default_nettype wire

// ---- rtl/abox_exec.sv ----
// abox_exec: decode and execute of add, bit clear, bit set and bit test/skip
// assumes: instr_word/instr_valid come from fetch logic on clk; load port from core logic
`timescale 1ns/10ps
`default_nettype none
module abox_exec
   import abox_pkg::*;
#(
   parameter int unsigned NREG_AW = abox_pkg::ADDR_W
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [abox_pkg::WORD_W-1:0] instr_word,
   input  wire logic                       instr_valid,
   input  wire logic                       load_we,
   input  wire logic [NREG_AW-1:0]         load_addr,
   input  wire logic [abox_pkg::DATA_W-1:0] load_data,
   output var  logic [abox_pkg::DATA_W-1:0] acc,
   output var  logic                       carry,
   output var  logic                       nibble_overflow_flag,
   output var  logic                       zero,
   output var  logic                       retired,
   output var  logic                       skip_nop,
   output var  logic                       file_we,
   output var  logic [NREG_AW-1:0]         file_addr,
   output var  logic [abox_pkg::DATA_W-1:0] file_data
);
   import abox_pkg::*;

   typedef struct packed {
      logic                v;
      abox_op_t            op;
      logic [NREG_AW-1:0]  addr;
      logic [BITSEL_W-1:0] bitp;
      logic                dest;
      logic                squash;
      logic [DATA_W-1:0]   acc;
      logic                c;
      logic                dc;
      logic                z;
      logic                retired;
      logic                skip_nop;
      logic                we;
      logic [NREG_AW-1:0]  waddr;
      logic [DATA_W-1:0]   wdata;
   } abox_state_t;

   abox_state_t s_r;
   abox_state_t s_nxt;
   logic [DATA_W-1:0] rd;
   logic              ex;
   logic [DATA_W:0]   sum9;
   logic [NIBBLE_POS:0] nib;
   logic [DATA_W-1:0] mask;
   logic              mem_we;
   logic [NREG_AW-1:0] mem_waddr;
   logic [DATA_W-1:0] mem_wdata;

   // decode of the freshly fetched word
   function automatic abox_op_t dec(input logic [WORD_W-1:0] w);
      abox_op_t o;
      o = OP_NONE;
      if (w[WORD_W-1:ADD_OP_LSB] == ADD_OP) begin
         o = OP_ADD;
      end else if (w[WORD_W-1:BIT_OP_LSB] == BCLR_OP) begin
         o = OP_BCLR;
      end else if (w[WORD_W-1:BIT_OP_LSB] == BSET_OP) begin
         o = OP_BSET;
      end else if (w[WORD_W-1:BIT_OP_LSB] == BTST_OP) begin
         o = OP_BTST;
      end
      return o;
   endfunction : dec

   // execute writes win over the load port
   assign mem_we    = s_nxt.we | load_we;
   assign mem_waddr = s_nxt.we ? s_nxt.waddr : load_addr;
   assign mem_wdata = s_nxt.we ? s_nxt.wdata : load_data;

   abox_file_mem #(
      .AW (NREG_AW),
      .DW (DATA_W)
   ) u_mem (
      .clk   (clk),
      .we    (mem_we),
      .waddr (mem_waddr),
      .wdata (mem_wdata),
      .raddr (instr_word[ADDR_LSB +: NREG_AW]),
      .rdata (rd)
   );

   always_comb begin
      s_nxt          = s_r;
      s_nxt.retired  = 1'b0;
      s_nxt.skip_nop = 1'b0;
      s_nxt.we       = 1'b0;
      ex   = s_r.v && !s_r.squash;
      sum9 = {1'b0, s_r.acc} + {1'b0, rd};
      nib  = {1'b0, s_r.acc[NIBBLE_POS-1:0]} + {1'b0, rd[NIBBLE_POS-1:0]};
      mask = DATA_W'(8'h01) << s_r.bitp;
      if (s_r.v && s_r.squash) begin
         s_nxt.skip_nop = 1'b1;
      end
      if (ex) begin
         s_nxt.retired = 1'b1;
         s_nxt.waddr   = s_r.addr;
         case (s_r.op)
            OP_ADD: begin
               s_nxt.c  = sum9[DATA_W];
               s_nxt.dc = nib[NIBBLE_POS];
               s_nxt.z  = (sum9[DATA_W-1:0] == '0);
               if (s_r.dest) begin
                  s_nxt.we    = 1'b1;
                  s_nxt.wdata = sum9[DATA_W-1:0];
               end else begin
                  s_nxt.acc = sum9[DATA_W-1:0];
               end
            end
            OP_BCLR: begin
               s_nxt.we    = 1'b1;
               s_nxt.wdata = rd & ~mask;
            end
            OP_BSET: begin
               s_nxt.we    = 1'b1;
               s_nxt.wdata = rd | mask;
            end
            default: begin
            end
         endcase
      end
      // a pending skip waits for the next real word, then cancels it
      s_nxt.squash = (ex && (s_r.op == OP_BTST) && !rd[s_r.bitp])
                     || (s_r.squash && !s_r.v);
      s_nxt.v    = instr_valid;
      s_nxt.op   = dec(instr_word);
      s_nxt.addr = instr_word[ADDR_LSB +: NREG_AW];
      s_nxt.bitp = instr_word[BITSEL_LSB +: BITSEL_W];
      s_nxt.dest = instr_word[DEST_POS];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r          <= '0;
         s_r.op       <= OP_NONE;
         s_r.acc      <= ACC_RST;
         s_r.c        <= FLAG_RST;
         s_r.dc       <= FLAG_RST;
         s_r.z        <= FLAG_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign acc                  = s_r.acc;
   assign carry                = s_r.c;
   assign nibble_overflow_flag = s_r.dc;
   assign zero                 = s_r.z;
   assign retired              = s_r.retired;
   assign skip_nop             = s_r.skip_nop;
   assign file_we              = s_r.we;
   assign file_addr            = s_r.waddr;
   assign file_data            = s_r.wdata;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_add_acc_sum: assert property (ex && s_r.op == OP_ADD && !s_r.dest
      |=> acc == $past(sum9[DATA_W-1:0]) && !file_we)
      else $error("add to accumulator wrong");
   a_add_flags: assert property (ex && s_r.op == OP_ADD
      |=> carry == $past(sum9[DATA_W]) && zero == (($past(sum9) & 9'h0FF) == 9'h000)
          && nibble_overflow_flag == $past(nib[NIBBLE_POS]))
      else $error("add flags wrong");
   a_add_file_dest: assert property (ex && s_r.op == OP_ADD && s_r.dest
      |=> file_we && file_data == $past(sum9[DATA_W-1:0]) && $stable(acc))
      else $error("add to file wrong");
   a_bclr_bit: assert property (ex && s_r.op == OP_BCLR
      |=> file_we && !file_data[$past(s_r.bitp)] && $stable(carry) && $stable(zero))
      else $error("bit clear wrong");
   a_bset_bit: assert property (ex && s_r.op == OP_BSET
      |=> file_we && file_data[$past(s_r.bitp)] && $stable(nibble_overflow_flag))
      else $error("bit set wrong");
   a_btst_noflag: assert property (ex && s_r.op == OP_BTST
      |=> !file_we && $stable(acc) && $stable(carry) && $stable(zero))
      else $error("bit test changed state");
   a_skip_nop: assert property (ex && s_r.op == OP_BTST && !rd[s_r.bitp] && instr_valid
      |=> ##1 skip_nop && !retired && !file_we)
      else $error("skip not taken");
   a_noskip: assert property (ex && s_r.op == OP_BTST && rd[s_r.bitp] && instr_valid
      |=> ##1 !skip_nop && retired)
      else $error("skip taken wrongly");
   a_single_cycle: assert property (ex && s_r.op != OP_BTST |=> retired)
      else $error("instruction not retired");

   c_add_carry: cover property (ex && s_r.op == OP_ADD ##1 carry);
   c_add_file:  cover property (ex && s_r.op == OP_ADD && s_r.dest);
   c_skip:      cover property (skip_nop);
   c_bset:      cover property (ex && s_r.op == OP_BSET ##1 ex && s_r.op == OP_BCLR);
endmodule : abox_exec
`default_nettype wire

// ---- dv/abox_exec_tb.sv ----
// testbench for abox_exec: table of single instructions, then skip cases, then a mid-run reset
// assumes: abox_pkg compiled first; the bench drives all inputs, with no partner model
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import abox_pkg::*;
   typedef struct packed {
      logic [6:0]  fa;
      logic [7:0]  fv;
      logic [13:0] word;
      logic [7:0]  acc;
      logic [3:0]  czdw;
      logic [7:0]  wd;
   } abox_tb_row_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [13:0] instr_word = 14'h0000;
   logic        instr_valid = 1'b0;
   logic        load_we = 1'b0;
   logic [6:0]  load_addr = 7'h00;
   logic [7:0]  load_data = 8'h00;
   logic [7:0]  acc, file_data;
   logic [6:0]  file_addr;
   logic        carry, nibble_overflow_flag, zero, retired, skip_nop, file_we;
   int          miscompares = 0;
   int          checks_done = 0;
   abox_tb_row_t rows [9];
   abox_exec uut (.clk(clk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
      .load_we(load_we), .load_addr(load_addr), .load_data(load_data), .acc(acc),
      .carry(carry), .nibble_overflow_flag(nibble_overflow_flag), .zero(zero),
      .retired(retired), .skip_nop(skip_nop), .file_we(file_we), .file_addr(file_addr),
      .file_data(file_data));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic preload(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      load_we = 1'b1;
      load_addr = a;
      load_data = d;
      @(negedge clk);
      load_we = 1'b0;
   endtask : preload
   // one word, then wait until its results have landed
   task automatic exec(input logic [13:0] w);
      @(negedge clk);
      instr_word = w;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      @(negedge clk);
   endtask : exec
   // bit test then the next word back to back; bit of 0x20 selects the skip
   task automatic skip_case(input logic [7:0] tv, input logic taken);
      preload(7'h20, tv);
      preload(7'h21, 8'h10);
      @(negedge clk);
      instr_word = 14'h1920;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_word = 14'h1421;
      @(negedge clk);
      instr_valid = 1'b0;
      check({7'h00, retired}, 8'h01);
      check({7'h00, skip_nop}, 8'h00);
      check({7'h00, file_we}, 8'h00);
      @(negedge clk);
      check({7'h00, skip_nop}, {7'h00, taken});
      check({7'h00, retired}, {7'h00, !taken});
      check({7'h00, file_we}, {7'h00, !taken});
      if (!taken) check(file_data, 8'h11);
      check({5'h00, carry, nibble_overflow_flag, zero}, 8'h02);
   endtask : skip_case
   initial begin
      #50000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      rows[0] = '{7'h10, 8'h17, 14'h0710, 8'h17, 4'b0000, 8'h00};
      rows[1] = '{7'h11, 8'hC2, 14'h0711, 8'hD9, 4'b0000, 8'h00};
      rows[2] = '{7'h12, 8'h27, 14'h0792, 8'hD9, 4'b1111, 8'h00};
      rows[3] = '{7'h13, 8'hC7, 14'h1393, 8'hD9, 4'b1111, 8'h47};
      rows[4] = '{7'h14, 8'h0A, 14'h1794, 8'hD9, 4'b1111, 8'h8A};
      rows[5] = '{7'h15, 8'hFF, 14'h1015, 8'hD9, 4'b1111, 8'hFE};
      rows[6] = '{7'h16, 8'h00, 14'h1596, 8'hD9, 4'b1111, 8'h08};
      rows[7] = '{7'h17, 8'h08, 14'h0717, 8'hE1, 4'b0100, 8'h00};
      rows[8] = '{7'h18, 8'h55, 14'h0000, 8'hE1, 4'b0100, 8'h00};
      repeat (20) @(negedge clk);
      check(acc, 8'h00);
      check({2'h0, carry, nibble_overflow_flag, zero, retired, skip_nop, file_we}, 8'h00);
      rst = 1'b0;
      @(negedge clk);
      check({1'h0, file_addr}, 8'h00);
      check(file_data, 8'h00);
      foreach (rows[i]) begin
         preload(rows[i].fa, rows[i].fv);
         exec(rows[i].word);
         check({7'h00, retired}, 8'h01);
         check(acc, rows[i].acc);
         check({4'h0, carry, nibble_overflow_flag, zero, file_we},
            {4'h0, rows[i].czdw});
         if (rows[i].czdw[0]) begin
            check(file_data, rows[i].wd);
            check({1'h0, file_addr}, {1'h0, rows[i].fa});
         end
         @(negedge clk);
         check({7'h00, retired}, 8'h00);
      end
      skip_case(8'hFB, 1'b1);
      skip_case(8'h04, 1'b0);
      // taken skip waits across an idle cycle for the next word
      preload(7'h20, 8'hFB);
      @(negedge clk);
      instr_word = 14'h1920;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      @(negedge clk);
      check({7'h00, retired}, 8'h01);
      instr_word = 14'h1421;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      @(negedge clk);
      check({7'h00, skip_nop}, 8'h01);
      check({7'h00, retired}, 8'h00);
      check({7'h00, file_we}, 8'h00);
      // reset in mid-run, then one add from the cleared accumulator
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      check(acc, 8'h00);
      check({5'h00, carry, nibble_overflow_flag, zero}, 8'h00);
      rst = 1'b0;
      preload(7'h30, 8'h05);
      exec(14'h0730);
      check(acc, 8'h05);
      check({7'h00, retired}, 8'h01);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
